// >>> core/handle_queue.v
`timescale 1ns/1ps
// queue of received packet handles, 32 deep
module handle_queue (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       push,
	input  wire [4:0] push_pkt,
	input  wire       pop,
	output wire [4:0] head,
	output wire       empty
);
	reg [4:0] slot [0:31];
	reg [5:0] wr_q;
	reg [5:0] rd_q;
	wire      full;

	assign empty = (wr_q == rd_q);
	assign full  = (wr_q[5] != rd_q[5]) && (wr_q[4:0] == rd_q[4:0]);
	// slots are not reset, so an empty queue shows handle zero, never a stale slot
	assign head  = empty ? 5'h00 : slot[rd_q[4:0]];

	// at most one packet per page, so a push into a full queue cannot happen
	always @(posedge core_clk)
	begin
		if (push && !full)
			slot[wr_q[4:0]] <= push_pkt;
	end

	// pointers move only on push and pop strobes
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= 6'h00;
			rd_q <= 6'h00;
		end
		else
		begin
			if (push && !full)
				wr_q <= wr_q + 6'h01;
			if (pop && !empty)
				rd_q <= rd_q + 6'h01;
		end
	end
endmodule // handle_queue

// >>> core/packet_buffer_manager.v
`timescale 1ns/1ps
`include "pbm_map.vh"
module packet_buffer_manager (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        cmd_wr,
	input  wire [7:0]  cmd_data,
	input  wire        pnum_wr,
	input  wire [7:0]  pnum_data,
	input  wire        ptr_low_wr,
	input  wire [7:0]  ptr_low_data,
	input  wire        ptr_high_wr,
	input  wire [7:0]  ptr_high_data,
	input  wire        data_strobe,
	input  wire [7:0]  data_wdata,
	input  wire [7:0]  irq0_mask,
	output reg  [7:0]  data_rdata,
	output wire        data_busy,
	output wire [7:0]  alloc_result,
	output wire [7:0]  rx_packet_queue,
	output wire [7:0]  packet_number_sel,
	output wire [7:0]  pointer_low,
	output wire [7:0]  pointer_high,
	output reg         rx_packet_irq,
	input  wire        sie_alloc_req,
	input  wire [3:0]  sie_alloc_pages_m1,
	output reg         sie_alloc_ack,
	output reg  [4:0]  sie_alloc_pkt,
	input  wire        sie_rx_done,
	input  wire [4:0]  sie_rx_pkt,
	input  wire [3:0]  sie_rx_ep,
	input  wire        sie_rx_crc_err,
	input  wire        sie_rx_last_tog,
	input  wire        sie_rx_same_tog,
	input  wire [10:0] sie_rx_count,
	output wire        sie_rx_busy,
	input  wire        sie_req,
	input  wire        sie_we,
	input  wire [4:0]  sie_pkt,
	input  wire [10:0] sie_off,
	input  wire [7:0]  sie_wdata,
	output wire        sie_ack,
	input  wire        dma_req,
	input  wire        dma_we,
	input  wire [4:0]  dma_pkt,
	input  wire [10:0] dma_off,
	input  wire [7:0]  dma_wdata,
	output wire        dma_ack,
	output reg  [7:0]  port_rdata
);
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_ALLOC = 4'b0010;
	localparam [3:0] ST_FREE  = 4'b0100;
	localparam [3:0] ST_DONE  = 4'b1000;

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	reg  [7:0]  mem     [0:4095];
	reg  [4:0]  chain   [0:319];
	reg  [3:0]  len     [0:31];
	reg  [31:0] used_q;
	reg  [3:0]  state_q;
	reg  [4:0]  cur_q;
	reg  [3:0]  idx_q;
	reg  [3:0]  need_q;
	reg         own_sie_q;
	reg         pend_q;
	reg  [3:0]  pend_n_q;
	reg  [4:0]  result_q;
	reg         rel_q;
	reg  [4:0]  rel_pkt_q;
	reg  [7:0]  pnum_q;
	reg  [7:0]  ptr_low_q;
	reg  [7:0]  ptr_high_q;
	reg  [10:0] off_q;
	reg         mcu_pend_q;
	reg  [7:0]  mcu_wd_q;
	reg  [1:0]  hdr_step_q;
	reg  [4:0]  hdr_pkt_q;
	reg  [7:0]  hdr_b0_q;
	reg  [10:0] hdr_cnt_q;
	reg  [4:0]  free_pkt;
	reg         pkt_avail;
	reg  [4:0]  sel_pkt;
	reg  [10:0] sel_off;
	reg         sel_we;
	reg  [7:0]  sel_wd;
	reg  [7:0]  hdr_byte;
	integer     i;
	wire [4:0]  low_free;
	wire [5:0]  free_cnt;
	wire [4:0]  q_head;
	wire        q_empty;
	wire        take;
	wire        give;
	wire [4:0]  give_page;
	wire        q_push;
	wire        q_pop;
	wire [2:0]  op;
	wire        gnt_hdr;
	wire        gnt_sie;
	wire        gnt_dma;
	wire        gnt_mcu;
	wire [4:0]  mcu_pkt;
	wire [3:0]  pg;
	wire [8:0]  slot;
	wire        hit;
	wire [11:0] phys;

	assign op = cmd_data[`CMD_OP_HI:`CMD_OP_LO];

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	page_pool u_pool (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.take      (take),
		.give      (give),
		.give_page (give_page),
		.low_free  (low_free),
		.free_cnt  (free_cnt)
	);

	handle_queue u_queue (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.push     (q_push),
		.push_pkt (hdr_pkt_q),
		.pop      (q_pop),
		.head     (q_head),
		.empty    (q_empty)
	);

	// ---------------------------------------------------------------
	// handle and page bookkeeping
	// ---------------------------------------------------------------
	// lowest unused handle; handles bear no relation to pages
	always @*
	begin
		free_pkt  = 5'h00;
		pkt_avail = 1'b0;
		for (i = 31; i >= 0; i = i - 1)
		begin
			if (!used_q[i])
			begin
				free_pkt  = i[4:0];
				pkt_avail = 1'b1;
			end
		end
	end

	assign slot      = ({4'h0, cur_q} * `SLOT_MAX) + {5'h00, idx_q};
	assign take      = (state_q == ST_ALLOC);
	assign give      = (state_q == ST_FREE) && used_q[cur_q];
	assign give_page = chain[slot];
	assign q_pop     = cmd_wr && ((op == `CMD_DEQ_FREE) || (op == `CMD_DEQ_KEEP));

	// one page per cycle: an allocation of 10 pages ends in 12 cycles
	always @(posedge core_clk)
	begin
		if (state_q == ST_ALLOC)
			chain[slot] <= low_free;
		if ((state_q == ST_ALLOC) && (idx_q == need_q))
			len[cur_q] <= need_q + 4'h1;
	end

	// allocate / release sequencer
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q       <= ST_IDLE;
			used_q        <= 32'h00000000;
			cur_q         <= 5'h00;
			idx_q         <= 4'h0;
			need_q        <= 4'h0;
			own_sie_q     <= 1'b0;
			result_q      <= 5'h00;
			sie_alloc_ack <= 1'b0;
			sie_alloc_pkt <= 5'h00;
		end
		else
		begin
			sie_alloc_ack <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					idx_q <= 4'h0;
					if (rel_q)
					begin
						cur_q   <= rel_pkt_q;
						state_q <= ST_FREE;
					end
					// waits here while pages run short
					else if (pend_q && pkt_avail && ({2'h0, pend_n_q} < free_cnt))
					begin
						cur_q          <= free_pkt;
						need_q         <= pend_n_q;
						own_sie_q      <= 1'b0;
						used_q[free_pkt] <= 1'b1;
						state_q        <= ST_ALLOC;
					end
					else if (sie_alloc_req && !sie_alloc_ack && pkt_avail
						&& ({2'h0, (sie_alloc_pages_m1 > `MAX_PAGES_M1) ? `MAX_PAGES_M1
						: sie_alloc_pages_m1} < free_cnt))
					begin
						cur_q          <= free_pkt;
						need_q         <= (sie_alloc_pages_m1 > `MAX_PAGES_M1) ?
							`MAX_PAGES_M1 : sie_alloc_pages_m1;
						own_sie_q      <= 1'b1;
						used_q[free_pkt] <= 1'b1;
						state_q        <= ST_ALLOC;
					end
				end
				ST_ALLOC:
				begin
					idx_q <= idx_q + 4'h1;
					if (idx_q == need_q)
						state_q <= ST_DONE;
				end
				ST_DONE:
				begin
					if (own_sie_q)
					begin
						sie_alloc_ack <= 1'b1;
						sie_alloc_pkt <= cur_q;
					end
					else
						result_q <= cur_q;
					state_q <= ST_IDLE;
				end
				ST_FREE:
				begin
					idx_q <= idx_q + 4'h1;
					if (!used_q[cur_q] || (idx_q + 4'h1 >= len[cur_q]))
					begin
						used_q[cur_q] <= 1'b0;
						state_q       <= ST_IDLE;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// processor command side
	// ---------------------------------------------------------------
	// pending set after the done clear so a new command is not lost
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_q    <= 1'b0;
			pend_n_q  <= 4'h0;
			rel_q     <= 1'b0;
			rel_pkt_q <= 5'h00;
		end
		else
		begin
			if ((state_q == ST_DONE) && !own_sie_q)
				pend_q <= 1'b0;
			if (cmd_wr && (op == `CMD_ALLOC))
			begin
				pend_q   <= 1'b1;
				pend_n_q <= (cmd_data[3:0] > `MAX_PAGES_M1) ? `MAX_PAGES_M1
					: cmd_data[3:0];
			end
			if ((state_q == ST_IDLE) && rel_q)
				rel_q <= 1'b0;
			// a release issued while one is queued replaces it
			if (cmd_wr && (op == `CMD_RELEASE))
			begin
				rel_q     <= 1'b1;
				rel_pkt_q <= pnum_q[4:0];
			end
			if (cmd_wr && (op == `CMD_DEQ_FREE) && !q_empty)
			begin
				rel_q     <= 1'b1;
				rel_pkt_q <= q_head;
			end
		end
	end

	assign alloc_result      = {pend_q, 2'h0, result_q};
	assign rx_packet_queue   = {q_empty, 2'h0, q_head};
	assign packet_number_sel = pnum_q;
	assign pointer_low       = off_q[7:0];
	assign pointer_high      = {ptr_high_q[7:3], off_q[10:8]};

	// ---------------------------------------------------------------
	// pointer registers and data port
	// ---------------------------------------------------------------
	// pointer-high write commits the staged low byte
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pnum_q     <= 8'h00;
			ptr_low_q  <= 8'h00;
			ptr_high_q <= 8'h00;
			off_q      <= 11'h000;
			mcu_pend_q <= 1'b0;
			mcu_wd_q   <= 8'h00;
		end
		else
		begin
			if (pnum_wr)
				pnum_q <= pnum_data;
			if (ptr_low_wr)
				ptr_low_q <= ptr_low_data;
			if (gnt_mcu)
				mcu_pend_q <= 1'b0;
			if (gnt_mcu && ptr_high_q[`PH_AUTO_INC])
				off_q <= off_q + 11'h001;
			if (ptr_high_wr)
			begin
				ptr_high_q <= ptr_high_data;
				off_q      <= {ptr_high_data[`PH_OFF_HI:0], ptr_low_q};
			end
			if (data_strobe)
			begin
				mcu_pend_q <= 1'b1;
				mcu_wd_q   <= data_wdata;
			end
		end
	end

	assign data_busy = mcu_pend_q;
	// queue head or numbered packet
	assign mcu_pkt   = ptr_high_q[`PH_RX_SEL] ? q_head : pnum_q[4:0];

	// ---------------------------------------------------------------
	// header writer for received packets
	// ---------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hdr_step_q <= 2'h0;
			hdr_pkt_q  <= 5'h00;
			hdr_b0_q   <= 8'h00;
			hdr_cnt_q  <= 11'h000;
		end
		else if (hdr_step_q != 2'h0)
			hdr_step_q <= hdr_step_q + 2'h1;
		else if (sie_rx_done)
		begin
			hdr_step_q <= 2'h1;
			hdr_pkt_q  <= sie_rx_pkt;
			hdr_b0_q   <= {sie_rx_crc_err, sie_rx_last_tog, sie_rx_same_tog,
				1'b0, sie_rx_ep};
			hdr_cnt_q  <= sie_rx_count;
		end
	end

	assign sie_rx_busy = (hdr_step_q != 2'h0);
	assign q_push      = (hdr_step_q == 2'h3);

	// one strobe per received packet, suppressed by the mask bit
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_packet_irq <= 1'b0;
		else
			rx_packet_irq <= q_push && !irq0_mask[`RX_IRQ_BIT];
	end

	// ---------------------------------------------------------------
	// arbitration and address translation
	// ---------------------------------------------------------------
	// fixed priority: header, serial engine, DMA, processor
	assign gnt_hdr = (hdr_step_q != 2'h0);
	assign gnt_sie = !gnt_hdr && sie_req;
	assign gnt_dma = !gnt_hdr && !sie_req && dma_req;
	assign gnt_mcu = !gnt_hdr && !sie_req && !dma_req && mcu_pend_q;
	assign sie_ack = gnt_sie;
	assign dma_ack = gnt_dma;

	always @*
	begin
		case (hdr_step_q)
			2'h1:    hdr_byte = hdr_b0_q;
			2'h2:    hdr_byte = hdr_cnt_q[7:0];
			default: hdr_byte = {5'h00, hdr_cnt_q[10:8]};
		endcase
		sel_pkt = mcu_pkt;
		sel_off = off_q;
		sel_we  = !ptr_high_q[`PH_READ];
		sel_wd  = mcu_wd_q;
		if (gnt_hdr)
		begin
			sel_pkt = hdr_pkt_q;
			sel_off = (hdr_step_q == 2'h1) ? `HDR_BYTE0_OFF :
				`HDR_COUNT_OFF + {10'h000, hdr_step_q[0]};
			sel_we  = 1'b1;
			sel_wd  = hdr_byte;
		end
		else if (gnt_sie)
		begin
			sel_pkt = sie_pkt;
			sel_off = sie_off;
			sel_we  = sie_we;
			sel_wd  = sie_wdata;
		end
		else if (gnt_dma)
		begin
			sel_pkt = dma_pkt;
			sel_off = dma_off;
			sel_we  = dma_we;
			sel_wd  = dma_wdata;
		end
	end

	// page boundaries hidden behind the chain table
	assign pg   = sel_off[10:`PAGE_OFF_W];
	assign hit  = used_q[sel_pkt] && (pg < len[sel_pkt]);
	assign phys = {chain[({4'h0, sel_pkt} * `SLOT_MAX) + {5'h00, pg}],
		sel_off[`PAGE_OFF_W-1:0]};

	// accesses past the packet end write nothing and read zero
	always @(posedge core_clk)
	begin
		if ((gnt_hdr || gnt_sie || gnt_dma || gnt_mcu) && hit && sel_we)
			mem[phys] <= sel_wd;
	end

	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_rdata <= 8'h00;
			port_rdata <= 8'h00;
		end
		else
		begin
			if (gnt_mcu && !sel_we)
				data_rdata <= hit ? mem[phys] : 8'h00;
			if ((gnt_sie || gnt_dma) && !sel_we)
				port_rdata <= hit ? mem[phys] : 8'h00;
		end
	end
endmodule // packet_buffer_manager

// >>> core/page_pool.v
`timescale 1ns/1ps
// free-page bitmap: lowest free page offered, count kept
module page_pool (
	input  wire       core_clk,
	input  wire       rst_n,
	input  wire       take,
	input  wire       give,
	input  wire [4:0] give_page,
	output reg  [4:0] low_free,
	output reg  [5:0] free_cnt
);
	reg     [31:0] free_q;
	integer        i;

	// ---------------------------------------------------------------
	// search and count
	// ---------------------------------------------------------------
	// descending scan so the lowest free page wins
	always @*
	begin
		low_free = 5'h00;
		free_cnt = 6'h00;
		for (i = 31; i >= 0; i = i - 1)
		begin
			if (free_q[i])
				low_free = i[4:0];
			free_cnt = free_cnt + {5'h00, free_q[i]};
		end
	end

	// whole pages only move in and out of the pool
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			free_q <= 32'hFFFFFFFF;
		else
		begin
			if (take)
				free_q[low_free] <= 1'b0;
			if (give)
				free_q[give_page] <= 1'b1;
		end
	end
endmodule // page_pool

// >>> core/pbm_map.vh
// Operation
// - 4 KB RAM, 32 pages of 128 bytes
// - every packet starts with 8-byte header
// - chain pages, at most 10 per packet
// - all ports see packets as linear bytes
// - allocate command reserves page count plus one
// - pending flag set until number is presented
// - allocation finishes within a few microseconds
// - release frees every page of numbered packet
// - packet numbers are handles, not addresses
// - received packets allocated and pushed on queue
// - dequeue with free, or dequeue keeping memory
// - queue register shows an empty flag
// - receive-select picks queue head, else number
// - direction bit and auto-increment of offset
// - offset 0 is header, count at 6
// - number-select serves packet number register
// - dequeue-free acts on queue head only
// - header byte 0 holds endpoint and flags
`ifndef PBM_MAP_VH
`define PBM_MAP_VH

// ---------------------------------------------------------------
// memory geometry
// ---------------------------------------------------------------
`define PAGE_COUNT      32
`define PAGE_OFF_W      7
`define RAM_BYTES       4096
`define MAX_PAGES       4'd10
`define MAX_PAGES_M1    4'd9
`define SLOT_MAX        9'd10

// ---------------------------------------------------------------
// command byte: op in [7:5], page count minus one in [3:0]
// ---------------------------------------------------------------
`define CMD_OP_HI       7
`define CMD_OP_LO       5
`define CMD_ALLOC       3'h1
`define CMD_RELEASE     3'h2
`define CMD_DEQ_FREE    3'h3
`define CMD_DEQ_KEEP    3'h4

// ---------------------------------------------------------------
// pointer-high fields
// ---------------------------------------------------------------
`define PH_RX_SEL       7
`define PH_READ         5
`define PH_AUTO_INC     4
`define PH_OFF_HI       2

// ---------------------------------------------------------------
// status bits, header layout, mask bit
// ---------------------------------------------------------------
`define PENDING_BIT     7
`define EMPTY_BIT       7
`define HDR_BYTE0_OFF   11'h000
`define HDR_COUNT_OFF   11'h006
`define HDR_CRC_BIT     7
`define HDR_LTOG_BIT    6
`define HDR_STOG_BIT    5
`define RX_IRQ_BIT      0

`endif

// >>> verif/packet_buffer_manager_tb_top.sv
`timescale 1ns/1ps
module packet_buffer_manager_tb_top;
	reg         core_clk, rst_n, cmd_wr, pnum_wr, ptr_low_wr, ptr_high_wr, data_strobe, go;
	reg  [7:0]  cmd_data, pnum_data, ptr_low_data, ptr_high_data, data_wdata, irq0_mask;
	reg  [7:0]  b0, b1, x0;
	reg  [4:0]  h0, h1, h2;
	reg  [3:0]  ep;
	reg  [2:0]  flags;
	reg  [10:0] len;
	reg  [1:0]  stall;
	reg         dma_req;
	reg  [4:0]  dma_pkt;
	reg  [10:0] dma_off;
	wire [7:0]  data_rdata, alloc_result, rx_packet_queue, pointer_low, pointer_high, sie_wdata;
	wire [7:0]  packet_number_sel, port_rdata;
	wire        dma_ack;
	wire        data_busy, rx_packet_irq, done, sie_alloc_req, sie_alloc_ack, sie_rx_done;
	wire        sie_rx_busy, sie_req, sie_we, sie_ack;
	wire [3:0]  sie_alloc_pages_m1, sie_rx_ep;
	wire [4:0]  sie_alloc_pkt, sie_rx_pkt, sie_pkt;
	wire [2:0]  sie_rx_flags;
	wire [10:0] sie_rx_count, sie_off;
	integer     mismatches, samples_checked, irq_cnt, k, n;

	packet_buffer_manager uut (.core_clk, .rst_n, .cmd_wr, .cmd_data, .pnum_wr, .pnum_data,
		.ptr_low_wr, .ptr_low_data, .ptr_high_wr, .ptr_high_data, .data_strobe, .data_wdata,
		.irq0_mask, .data_rdata, .data_busy, .alloc_result, .rx_packet_queue,
		.packet_number_sel, .pointer_low, .pointer_high, .rx_packet_irq, .sie_alloc_req,
		.sie_alloc_pages_m1, .sie_alloc_ack, .sie_alloc_pkt, .sie_rx_done, .sie_rx_pkt,
		.sie_rx_ep, .sie_rx_crc_err(sie_rx_flags[2]), .sie_rx_last_tog(sie_rx_flags[1]),
		.sie_rx_same_tog(sie_rx_flags[0]), .sie_rx_count, .sie_rx_busy, .sie_req, .sie_we,
		.sie_pkt, .sie_off, .sie_wdata, .sie_ack, .dma_req, .dma_we(1'b0),
		.dma_pkt, .dma_off, .dma_wdata(8'h00), .dma_ack, .port_rdata);
	sie_stub far (.core_clk, .go, .ep, .flags, .len, .stall, .done, .sie_alloc_req,
		.sie_alloc_pages_m1, .sie_alloc_ack, .sie_alloc_pkt, .sie_rx_done, .sie_rx_pkt,
		.sie_rx_ep, .sie_rx_flags, .sie_rx_count, .sie_rx_busy, .sie_req, .sie_we, .sie_pkt,
		.sie_off, .sie_wdata, .sie_ack);

	// ----------
	// helpers
	// ----------
	function [7:0] hdr0(input [2:0] f, input [3:0] e);
		hdr0 = {f, 1'b0, e};
	endfunction
	function [7:0] pay(input [10:0] o);
		pay = o[7:0] ^ 8'h5A;
	endfunction
	task test_done;
	begin
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task hang;
	begin
		mismatches = mismatches + 1;
		test_done;
	end
	endtask
	task check(input [10:0] seen, input [10:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			mismatches = mismatches + 1;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	end
	endtask
	// one-cycle write pulse: 0 command, 1 number, 2 pointer low, 3 pointer high
	task wr(input [1:0] r, input [7:0] d);
	begin
		@(negedge core_clk);
		{cmd_wr, pnum_wr, ptr_low_wr, ptr_high_wr} = 4'h8 >> r;
		{cmd_data, pnum_data, ptr_low_data, ptr_high_data} = {4{d}};
		@(negedge core_clk);
		{cmd_wr, pnum_wr, ptr_low_wr, ptr_high_wr} = 4'h0;
	end
	endtask
	task point(input [7:0] hi, input [10:0] o);
	begin
		wr(2, o[7:0]);
		wr(3, hi | {5'h00, o[10:8]});
	end
	endtask
	task dport(input [7:0] d, output [7:0] q);
	begin
		@(negedge core_clk);
		data_strobe = 1'b1;
		data_wdata = d;
		@(negedge core_clk);
		data_strobe = 1'b0;
		n = 0;
		while (data_busy !== 1'b0 && n < 100)
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		if (n == 100)
			hang;
		q = data_rdata;
	end
	endtask
	task pend_wait;
	begin
		n = 0;
		while (alloc_result[7] !== 1'b0 && n < 300)
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		if (n == 300)
			hang;
	end
	endtask
	task alloc(input [3:0] m1, output [4:0] h);
	begin
		wr(0, {4'h2, m1});
		check(alloc_result[7], 1'b1);
		pend_wait;
		check(n[10:0], (m1 > 4'd9) ? 11'd12 : m1 + 11'd3);
		h = alloc_result[4:0];
	end
	endtask
	task rel(input [4:0] h);
	begin
		wr(1, {3'h0, h});
		wr(0, 8'h40);
	end
	endtask
	task rx(input [1:0] st);
	begin
		ep = $urandom;
		flags = $urandom;
		len = 11'd1 + 11'($urandom % 150);
		stall = st;
		@(negedge core_clk) go = 1'b1;
		@(negedge core_clk) go = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000)
		begin
			@(negedge core_clk);
			n = n + 1;
		end
		if (n == 3000)
			hang;
		repeat (8) @(negedge core_clk);
	end
	endtask

	// free-running clock and interrupt pulse count
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (rx_packet_irq === 1'b1)
			irq_cnt <= irq_cnt + 1;

	// ----------
	// main sequence
	// ----------
	initial
	begin
		{cmd_wr, pnum_wr, ptr_low_wr, ptr_high_wr, data_strobe, go, rst_n} = 7'h00;
		{cmd_data, pnum_data, ptr_low_data, ptr_high_data, data_wdata, irq0_mask} = 48'h0;
		{ep, flags, len, stall} = 20'h0;
		{dma_req, dma_pkt, dma_off} = 17'h0;
		{mismatches, samples_checked, irq_cnt} = 96'h0;
		n = $urandom(41719);
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		check(alloc_result, 8'h00);
		check(rx_packet_queue, 8'h80);
		$display("reset test done");
		// allocations and a write/read run across a page seam
		alloc(4'($urandom % 3), h0);
		alloc(4'($urandom % 3), h1);
		alloc(4'h1, h2);
		check((h0 == h1) || (h1 == h2) || (h0 == h2), 1'b0);
		wr(1, {3'h0, h2});
		check(packet_number_sel, {3'h0, h2});
		point(8'h10, 11'd120);
		for (k = 0; k < 16; k = k + 1)
			dport(pay(k[10:0]), b0);
		check({pointer_high[2:0], pointer_low}, 11'd136);
		repeat (125) @(negedge core_clk);
		point(8'h30, 11'd120);
		for (k = 0; k < 16; k = k + 1)
		begin
			dport(8'h00, b0);
			check(b0, pay(k[10:0]));
		end
		rel(h0);
		rel(h1);
		rel(h2);
		repeat (60) @(negedge core_clk);
		$display("allocation test done");
		// pool exhaustion holds a request until pages return
		alloc(4'hF, h0);
		alloc(4'hF, h1);
		alloc(4'h9, h2);
		wr(0, 8'h22);
		repeat (50) @(negedge core_clk);
		check(alloc_result[7], 1'b1);
		rel(h0);
		pend_wait;
		h0 = alloc_result[4:0];
		rel(h0);
		rel(h1);
		rel(h2);
		repeat (60) @(negedge core_clk);
		$display("exhaustion test done");
		// receptions, header fields, queue disposal
		rx(2'd0);
		check(irq_cnt[10:0], 11'd1);
		check(rx_packet_queue[7], 1'b0);
		h0 = rx_packet_queue[4:0];
		x0 = hdr0(flags, ep);
		point(8'hB0, 11'd0);
		dport(8'h00, b0);
		check(b0, x0);
		point(8'hB0, 11'd6);
		dport(8'h00, b0);
		dport(8'h00, b1);
		check({b1[2:0], b0}, len);
		dport(8'h00, b0);
		check(b0, pay(11'd8));
		// same payload byte seen linearly through the DMA port
		@(negedge core_clk);
		{dma_req, dma_pkt, dma_off} = {1'b1, h0, 11'd8};
		#1 check(dma_ack, 1'b1);
		@(negedge core_clk);
		dma_req = 1'b0;
		check(port_rdata, pay(11'd8));
		irq0_mask = 8'h01;
		rx(2'd3);
		check(irq_cnt[10:0], 11'd1);
		check(rx_packet_queue, {3'h0, h0});
		wr(0, 8'h80);
		@(negedge core_clk);
		check(rx_packet_queue[7] || rx_packet_queue[4:0] == h0, 1'b0);
		wr(1, {3'h0, h0});
		point(8'h20, 11'd0);
		dport(8'h00, b0);
		check(b0, x0);
		for (k = 0; k < 2; k = k + 1)
		begin
			wr(0, 8'h60);
			@(negedge core_clk);
			check(rx_packet_queue, 8'h80);
		end
		rel(h0);
		repeat (60) @(negedge core_clk);
		for (k = 0; k < 5; k = k + 1)
			alloc((k < 3) ? 4'hF : 4'h0, h1);
		$display("receive test done");
		test_done;
	end
endmodule // packet_buffer_manager_tb_top

// >>> verif/pbm_checker_assertions.sv
`timescale 1ns/1ps
// ----------
// port checks
// ----------
module pbm_checker (
	input wire       core_clk,
	input wire       rst_n,
	input wire       cmd_wr,
	input wire [7:0] cmd_data,
	input wire       ptr_high_wr,
	input wire [7:0] ptr_high_data,
	input wire       data_strobe,
	input wire       data_busy,
	input wire [7:0] irq0_mask,
	input wire [7:0] alloc_result,
	input wire [7:0] rx_packet_queue,
	input wire [7:0] pointer_low,
	input wire [7:0] pointer_high,
	input wire       rx_packet_irq,
	input wire       sie_rx_done,
	input wire       sie_rx_busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// decoded allocate strobe and live byte offset
	wire        alloc_cmd = cmd_wr && cmd_data[7:5] == 3'h1;
	wire [10:0] offs      = {pointer_high[2:0], pointer_low};

	AST_ALLOC_BUSY: assert property (
		alloc_cmd |=> alloc_result[7] [*3])
		else $error("allocation result cleared too early");
	AST_RX_IRQ: assert property (
		sie_rx_done && !sie_rx_busy && !irq0_mask[0] |-> ##4 rx_packet_irq)
		else $error("receive interrupt missing");
	AST_IRQ_MASK: assert property (
		irq0_mask[0] && $past(irq0_mask[0]) |-> !rx_packet_irq)
		else $error("masked receive interrupt raised");
	AST_IRQ_QUEUE: assert property (
		rx_packet_irq |=> !rx_packet_queue[7])
		else $error("queue empty after receive");
	AST_QUEUE_HOLD: assert property (
		!rx_packet_queue[7] && !cmd_wr && !$past(cmd_wr) |=> $stable(rx_packet_queue))
		else $error("queue head moved without command");
	AST_DATA_BUSY: assert property (
		data_strobe |=> data_busy)
		else $error("data access not pending");
	AST_AUTO_INC: assert property (
		$fell(data_busy) && pointer_high[4] |-> offs == $past(offs) + 11'h001)
		else $error("offset not advanced");
	AST_PTR_COMMIT: assert property (
		ptr_high_wr |=> pointer_high[7:3] == $past(ptr_high_data[7:3]))
		else $error("pointer high not committed");
endmodule // pbm_checker

bind packet_buffer_manager pbm_checker u_pbm_checker (.core_clk, .rst_n, .cmd_wr,
	.cmd_data, .ptr_high_wr, .ptr_high_data, .data_strobe, .data_busy, .irq0_mask,
	.alloc_result, .rx_packet_queue, .pointer_low, .pointer_high, .rx_packet_irq,
	.sie_rx_done, .sie_rx_busy);

// >>> verif/sie_stub.sv
`timescale 1ns/1ps
// ----------
// serial engine stand-in
// ----------
module sie_stub (
	input  wire        core_clk,
	input  wire        go,
	input  wire [3:0]  ep,
	input  wire [2:0]  flags,
	input  wire [10:0] len,
	input  wire [1:0]  stall,
	output reg         done,
	output reg         sie_alloc_req,
	output reg  [3:0]  sie_alloc_pages_m1,
	input  wire        sie_alloc_ack,
	input  wire [4:0]  sie_alloc_pkt,
	output reg         sie_rx_done,
	output reg  [4:0]  sie_rx_pkt,
	output reg  [3:0]  sie_rx_ep,
	output reg  [2:0]  sie_rx_flags,
	output reg  [10:0] sie_rx_count,
	input  wire        sie_rx_busy,
	output reg         sie_req,
	output reg         sie_we,
	output reg  [4:0]  sie_pkt,
	output reg  [10:0] sie_off,
	output reg  [7:0]  sie_wdata,
	input  wire        sie_ack
);
	integer    i, n;
	reg [10:0] span;
	// one reception per rising go: allocate, fill payload, report
	initial
	begin
		{done, sie_alloc_req, sie_rx_done, sie_req, sie_we} = 5'h00;
		{sie_alloc_pages_m1, sie_rx_pkt, sie_rx_ep, sie_rx_flags} = 16'h0000;
		{sie_rx_count, sie_pkt, sie_off, sie_wdata} = 35'h0;
		forever
		begin
			@(posedge go);
			done = 1'b0;
			@(negedge core_clk);
			// header plus payload, rounded up to whole pages
			span = len + 11'd7;
			sie_alloc_pages_m1 = span[10:7];
			sie_alloc_req = 1'b1;
			n = 0;
			while (sie_alloc_ack !== 1'b1 && n < 2000)
			begin
				@(negedge core_clk);
				n = n + 1;
			end
			// hold the request over the edge that samples the ack high
			@(negedge core_clk);
			sie_alloc_req = 1'b0;
			sie_pkt = sie_alloc_pkt;
			// payload bytes follow the header; grant sampled before each edge
			for (i = 0; i < len; i = i + 1)
			begin
				{sie_req, sie_we} = 2'b11;
				sie_off = 11'd8 + i[10:0];
				sie_wdata = sie_off[7:0] ^ 8'h5A;
				#1;
				while (sie_ack !== 1'b1 && n < 4000)
				begin
					@(negedge core_clk);
					#1;
					n = n + 1;
				end
				@(negedge core_clk);
				if (stall != 2'd0)
				begin
					{sie_req, sie_we} = 2'b00;
					sie_wdata = ~sie_wdata; // released lines never keep the old byte
					repeat (stall) @(negedge core_clk);
				end
			end
			{sie_req, sie_we} = 2'b00;
			{sie_off, sie_wdata} = ~{sie_off, sie_wdata};
			while (sie_rx_busy !== 1'b0 && n < 6000)
			begin
				@(negedge core_clk);
				n = n + 1;
			end
			sie_rx_done = 1'b1;
			{sie_rx_pkt, sie_rx_ep, sie_rx_flags, sie_rx_count} = {sie_pkt, ep, flags, len};
			@(negedge core_clk);
			sie_rx_done = 1'b0;
			{sie_rx_pkt, sie_rx_ep, sie_rx_flags} = ~{sie_rx_pkt, sie_rx_ep, sie_rx_flags};
			sie_rx_count = ~sie_rx_count;
			done = 1'b1;
		end
	end
endmodule // sie_stub
